// ===== hdl/rbf_chan.sv
`timescale 1ns/1ps

// ==========================================================
// One buffer channel: A copy and B copy flops
// ==========================================================
module rbf_chan
  import rbf_pkg::*;
(
  input  wire logic i_core_clk,  // Core clock
  input  wire logic i_rst_n,     // Synchronous reset, active low
  input  wire logic i_load,      // Capture this cycle
  input  wire logic i_d,         // Data input of the channel
  input  wire logic i_used_a,    // A copy exists in this layout
  input  wire logic i_used_b,    // B copy exists in this layout
  output logic      o_q_a,       // A copy output
  output logic      o_q_b        // B copy output
);

  // A copy register, holds between loads
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_q_a <= OUT_RESET[0];
    end else if (!i_used_a) begin
      o_q_a <= OUT_RESET[0];      // Unused terminal driven low
    end else if (i_load) begin
      o_q_a <= i_d;
    end
  end

  // B copy register, loaded with A so both carry one value while both are used
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_q_b <= OUT_RESET[0];
    end else if (!i_used_b) begin
      o_q_b <= OUT_RESET[0];
    end else if (i_load) begin
      o_q_b <= i_d;
    end
  end

endmodule

// ===== hdl/rbf_pkg.sv
package rbf_pkg;

  // ==========================================================
  // Channel counts
  // ==========================================================
  localparam int NUM_CH    = 25;   // Channels in the 1:1 layout
  localparam int NARROW_CH = 14;   // Channels in either 1:2 layout

  // Channel index of the primary chip select (input 7)
  localparam int CH_SELECT = 6;

  // ==========================================================
  // Layout masks, bit n is channel n+1
  // ==========================================================
  localparam logic [24:0] USED_WIDE     = 25'h1FFFFFF; // 1:1 channels in use
  localparam logic [24:0] USED_NARROW   = 25'h0003FFF; // 1:2 channels in use
  localparam logic [24:0] GATED_1TO1    = 25'h1FFFFB6; // All but 1, 4, 7
  localparam logic [24:0] GATED_REG_A   = 25'h0003FB6; // 2,3,5,6,8-14
  localparam logic [24:0] GATED_REG_B   = 25'h0001BBF; // All but 7, 11, 14

  // ==========================================================
  // Reset levels
  // ==========================================================
  localparam logic [24:0] OUT_RESET     = 25'h0000000; // Outputs cleared
  localparam logic        CLK_TRUE_RST  = 1'b0;        // True clock idle level
  localparam logic        CLK_COMP_RST  = 1'b1;        // Complement idle level

  // ==========================================================
  // Types
  // ==========================================================
  // Configuration select pair
  typedef struct packed {
    logic layout_width_select;  // Low 25-bit 1:1, high 14-bit 1:2
    logic layout_bank_select;   // Low register A, high register B
  } rbf_cfg_t;

  // Differential clock pair as sampled pins
  typedef struct packed {
    logic clk_true;             // True clock
    logic clk_comp;             // Complementary clock
  } rbf_clk_pair_t;

  // Decoded layout
  typedef enum logic [2:0] {
    RBF_LAYOUT_1TO1  = 3'b001,
    RBF_LAYOUT_REG_A = 3'b010,
    RBF_LAYOUT_REG_B = 3'b100
  } rbf_layout_t;

endpackage

// ===== hdl/rbf_top.sv
`timescale 1ns/1ps

// Operation
// - Register B: 14 inputs, A and B copies
// - Register B gates all but channels 7, 11, 14
// - 1:1 gates all but channels 1, 4, 7
// - Register A gates 2,3,5,6,8-14 only
// - Capture data at true-rise, complement-fall crossing
// - Both selects high freezes gated outputs
// - Either select low: gated output follows input
// - Select, termination, clock-enable channels always capture
// - Termination and clock-enable never frozen
// - Reset clears channel registers, forces outputs low
// - Unused terminals: inputs ignored, outputs low
// - Two selects choose among three layouts
// - Width select 1:1/1:2, bank select A/B

module rbf_top
  import rbf_pkg::*;
#(
  parameter int N_CH = NUM_CH,     // Channels in the 1:1 layout
  parameter int N_NR = NARROW_CH   // Channels in a 1:2 layout
) (
  input  wire logic          i_core_clk,            // Core clock, 40 MHz
  input  wire logic          i_rst_n,               // Synchronous reset, active low
  input  wire rbf_cfg_t      i_cfg,                 // Layout selects, held fixed
  input  wire rbf_clk_pair_t i_clk_pair,            // Sampled differential clock
  input  wire logic [N_CH-1:0] i_data,              // Data inputs, channel n at bit n-1
  input  wire logic          i_secondary_select_in, // Second chip select, active low
  output logic [N_CH-1:0]    o_q_a,                 // A outputs (sole outputs in 1:1)
  output logic [N_NR-1:0]    o_q_b                  // B copies in 1:2 layouts
);

  // ==========================================================
  // Clock pair sampling and crossing detect
  // ==========================================================
  // Sampled levels from the previous core edge
  logic clk_true_q;   // Last true clock level
  logic clk_comp_q;   // Last complement level

  // Previous clock levels, idle pattern under reset
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      clk_true_q <= CLK_TRUE_RST;
      clk_comp_q <= CLK_COMP_RST;
    end else begin
      clk_true_q <= i_clk_pair.clk_true;
      clk_comp_q <= i_clk_pair.clk_comp;
    end
  end

  // Both pins must toggle between samples; a pair
  // that only half switches is not a crossing
  // True rising while complement falling
  wire crossing = i_clk_pair.clk_true & ~clk_true_q
                & ~i_clk_pair.clk_comp & clk_comp_q;

  // ==========================================================
  // Layout decode
  // ==========================================================
  // Width low: 25-bit 1:1, no B copies
  // Width high, bank low: register A
  // Width high, bank high: register B
  wire rbf_layout_t layout =
    !i_cfg.layout_width_select ? RBF_LAYOUT_1TO1 :
    (i_cfg.layout_bank_select ? RBF_LAYOUT_REG_B : RBF_LAYOUT_REG_A);

  // Channels present on A outputs
  wire [N_CH-1:0] used_a =
    (layout == RBF_LAYOUT_1TO1) ? USED_WIDE : USED_NARROW;

  // Channels present on B outputs, none in 1:1
  wire [N_CH-1:0] used_b =
    (layout == RBF_LAYOUT_1TO1) ? OUT_RESET : USED_NARROW;

  // Channels frozen by chip-select gating
  wire [N_CH-1:0] gated =
    (layout == RBF_LAYOUT_1TO1)  ? GATED_1TO1  :
    (layout == RBF_LAYOUT_REG_A) ? GATED_REG_A : GATED_REG_B;

  // ==========================================================
  // Chip-select gating
  // ==========================================================
  // Chip selects are active low; both high means idle
  wire primary_select_in = i_data[CH_SELECT];           // Channel 7 is chip select
  wire freeze = primary_select_in & i_secondary_select_in;

  // Gated bits may load only while a select is low
  wire [N_CH-1:0] unfrozen = ~gated | {N_CH{~freeze}};

  // Gated bits load only when unfrozen, others every crossing
  wire [N_CH-1:0] load = {N_CH{crossing}} & unfrozen;

  // ==========================================================
  // Channel registers
  // ==========================================================
  // One channel per bit; B flops beyond the narrow
  // count stay cleared and are left unread.
  // Unused bits clear every edge, so a layout change
  // under reset leaves no stale value behind
  genvar g;
  generate
    for (g = 0; g < N_CH; g++) begin : g_ch
      logic q_b;   // B copy, used only below narrow count
      rbf_chan u_chan (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_load     (load[g]),
        .i_d        (i_data[g]),
        .i_used_a   (used_a[g]),
        .i_used_b   (used_b[g]),
        .o_q_a      (o_q_a[g]),
        .o_q_b      (q_b)
      );
      if (g < N_NR) begin : g_b
        assign o_q_b[g] = q_b;  // B copy straight from its flop
      end
    end
  endgenerate

  // ==========================================================
  // Checks
  // ==========================================================
  // Layout moves only under reset, so most checks ask
  // for stable selects across the attempt

  // Unfrozen crossing loads every used channel
  property p_capture;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    crossing && !freeze && $stable(i_cfg) |=> o_q_a == $past(i_data & used_a);
  endproperty
  a_capture: assert property (p_capture)
    else $error("Crossing did not capture data");

  // Frozen crossing keeps gated A outputs
  property p_freeze;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    crossing && freeze && $stable(i_cfg) |=> (o_q_a & gated) == $past(o_q_a & gated);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("Gated output changed while frozen");

  // Ungated channels load on every crossing
  property p_ungated;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    crossing && $stable(i_cfg)
      |=> (o_q_a & ~gated & used_a) == $past(i_data & ~gated & used_a);
  endproperty
  a_ungated: assert property (p_ungated)
    else $error("Ungated channel missed a crossing");

  // Idle pair leaves every output alone
  property p_hold;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    !crossing && $stable(i_cfg) ##1 i_rst_n |-> $stable(o_q_a) && $stable(o_q_b);
  endproperty
  a_hold: assert property (p_hold)
    else $error("Output moved without a crossing");

  // Reset clears both output banks
  property p_reset;
    @(posedge i_core_clk)
    !i_rst_n |=> o_q_a == OUT_RESET && o_q_b == OUT_RESET[N_NR-1:0];
  endproperty
  a_reset: assert property (p_reset)
    else $error("Outputs not low after reset");

  // A and B copies agree in 1:2
  property p_copy;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_cfg.layout_width_select |-> o_q_b == o_q_a[N_NR-1:0];
  endproperty
  a_copy: assert property (p_copy)
    else $error("A and B copies differ");

  // Unused A outputs stay low
  property p_unused_a;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    $stable(i_cfg) |=> (o_q_a & ~used_a) == OUT_RESET;
  endproperty
  a_unused_a: assert property (p_unused_a)
    else $error("Unused output not low");

  // No B outputs in 1:1
  property p_narrow_b;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    !i_cfg.layout_width_select && $stable(i_cfg) |=> o_q_b == OUT_RESET[N_NR-1:0];
  endproperty
  a_narrow_b: assert property (p_narrow_b)
    else $error("B outputs active in 1:1 layout");

  // Frozen crossing keeps gated B copies
  property p_freeze_b;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    crossing && freeze && $stable(i_cfg)
      |=> (o_q_b & gated[N_NR-1:0]) == $past(o_q_b & gated[N_NR-1:0]);
  endproperty
  a_freeze_b: assert property (p_freeze_b)
    else $error("Gated B copy changed while frozen");

  // Unfrozen crossing in 1:2 loads every B copy
  property p_capture_b;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    crossing && !freeze && i_cfg.layout_width_select && $stable(i_cfg)
      |=> o_q_b == $past(i_data[N_NR-1:0]);
  endproperty
  a_capture_b: assert property (p_capture_b)
    else $error("B copy missed an unfrozen crossing");

  // Primary select output follows its input on any crossing
  property p_select_out;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    crossing && $stable(i_cfg) |=> o_q_a[CH_SELECT] == $past(i_data[CH_SELECT]);
  endproperty
  a_select_out: assert property (p_select_out)
    else $error("Primary select output missed a crossing");

  // Upper A outputs stay low in 1:2
  property p_wide_unused;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_cfg.layout_width_select && $stable(i_cfg)
      |=> o_q_a[N_CH-1:N_NR] == OUT_RESET[N_CH-1:N_NR];
  endproperty
  a_wide_unused: assert property (p_wide_unused)
    else $error("Upper A output active in 1:2 layout");

  // Register B clock enable passes a frozen crossing
  property p_cke_b;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    crossing && freeze && layout == RBF_LAYOUT_REG_B && $stable(i_cfg)
      |=> o_q_a[N_NR-1] == $past(i_data[N_NR-1]) && o_q_b[N_NR-1] == $past(i_data[N_NR-1]);
  endproperty
  a_cke_b: assert property (p_cke_b)
    else $error("Register B clock enable frozen");

endmodule

// ===== verif/rbf_ctrl_model.sv
`timescale 1ns/1ps

// ==========================================================
// Controller side: differential clock pair
// ==========================================================
module rbf_ctrl_model
  import rbf_pkg::*;
(
  input  wire logic     i_strobe,   // Request one crossing
  output rbf_clk_pair_t o_clk_pair  // Differential clock levels
);
  // Pair stands idle (true low, comp high) outside crossings
  assign o_clk_pair = i_strobe ? 2'h2 : 2'h1;
endmodule

// ===== verif/rbf_top_tb.sv
`timescale 1ns/1ps

// ==========================================================
// Bench for the registered buffer
// ==========================================================
module rbf_top_tb;
  import rbf_pkg::*;
  typedef struct packed {
    logic [24:0] a;  // Expected A outputs
    logic [13:0] b;  // Expected B copies
  } rbf_exp_t;
  localparam logic [24:0] GT [3] = '{25'h1FFFFB6, 25'h0003FB6, 25'h0001BBF}; // Gated sets
  localparam logic [24:0] US [3] = '{25'h1FFFFFF, 25'h0003FFF, 25'h0003FFF}; // Used sets
  localparam logic [1:0]  CF [3] = '{2'b00, 2'b10, 2'b11};                   // Width, bank
  logic          i_core_clk;            // Core clock
  logic          i_rst_n;               // Reset, active low
  logic          i_secondary_select_in; // Second select, active low
  logic          strobe;                // Crossing request
  rbf_cfg_t      i_cfg;                 // Layout selects
  rbf_clk_pair_t i_clk_pair;            // Clock pair from model
  logic [24:0]   i_data;                // Data inputs
  logic [24:0]   o_q_a;                 // A outputs
  logic [13:0]   o_q_b;                 // B outputs
  logic [24:0]   exp_a;                 // Reference register state
  logic [24:0]   gate;                  // Gated channels of layout
  logic [24:0]   used;                  // Used channels of layout
  logic [31:0]   seed;                  // Random state
  rbf_exp_t      note;                  // Note under compare
  rbf_exp_t      note_q [$];            // Pending expectations
  int            num_errors;            // Mismatch count
  int            tests_run;             // Comparison count

  rbf_ctrl_model ctrl (.i_strobe(strobe), .o_clk_pair(i_clk_pair));
  rbf_top dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_cfg(i_cfg),
    .i_clk_pair(i_clk_pair), .i_data(i_data),
    .i_secondary_select_in(i_secondary_select_in), .o_q_a(o_q_a), .o_q_b(o_q_b));

  // ==========================================================
  // Clock and helpers
  // ==========================================================
  initial begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
  endfunction

  task automatic cmp_a(input logic [24:0] got, input logic [24:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_b(input logic [13:0] got, input logic [13:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One two-cycle slot: drive, note expectation, return pair to idle
  task automatic xfer(input logic [24:0] d, input logic cs2, input logic go, input logic rst);
    @(negedge i_core_clk);
    i_data = d;
    i_secondary_select_in = cs2;
    strobe = go;
    i_rst_n = !rst;
    if (rst) exp_a = 25'h0000000;
    else if (go && d[6] && cs2) exp_a = (exp_a & gate) | (d & ~gate & used);
    else if (go) exp_a = d & used;
    note_q.push_back({exp_a, i_cfg.layout_width_select ? exp_a[13:0] : 14'h0000});
    @(negedge i_core_clk);
    strobe = 1'b0;
  endtask

  // ==========================================================
  // Output watcher: one result at the next posedge after each note
  // ==========================================================
  initial forever begin
    @(posedge i_core_clk);
    #1;
    if (note_q.size() > 0) begin
      note = note_q.pop_front();
      cmp_a(o_q_a, note.a);
      cmp_b(o_q_b, note.b);
    end
  end

  // Backstop against a hung run
  initial begin
    #2000000;
    num_errors++;
    stop_test();
  end

  // ==========================================================
  // Main sequence: every layout in turn
  // ==========================================================
  initial begin
    i_rst_n = 1'b0;
    strobe = 1'b0;
    i_data = 25'h0000000;
    i_secondary_select_in = 1'b1;
    i_cfg = 2'b00;
    exp_a = 25'h0000000;
    gate = GT[0];
    used = US[0];
    seed = 32'h000073DB;
    num_errors = 0;
    tests_run = 0;
    repeat (10) @(posedge i_core_clk);
    for (int l = 0; l < 3; l++) begin
      xfer(25'h0000000, 1'b1, 1'b0, 1'b1);
      i_cfg = CF[l];
      gate = GT[l];
      used = US[l];
      xfer(25'h1FFFFFF, 1'b0, 1'b1, 1'b1);
      xfer(25'h1FFFFFF, 1'b0, 1'b1, 1'b0);
      xfer(25'h0000040, 1'b1, 1'b1, 1'b0);
      xfer(25'h0000000, 1'b0, 1'b0, 1'b0);
      for (int n = 0; n < 40; n++) begin
        seed = lfsr(seed);
        xfer(seed[24:0], seed[25], seed[26] | seed[27], 1'b0);
      end
      seed = lfsr(seed);
      xfer(seed[24:0], 1'b0, 1'b1, 1'b1);
      $display("Layout %0d done", l);
    end
    stop_test();
  end
endmodule
